// ---- include/acs_pkg.sv ----
// Package for the channel and setup configuration register bank.
// Assumes a 32-bit APB master on pclk; registers are word aligned.
package acs_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register indices; printed offsets are not all multiples of four
	localparam logic [7:0]  CHAN_IDX_FIRST  = 8'h10;
	localparam logic [7:0]  SETUP_IDX_FIRST = 8'h20;
	localparam logic [7:0]  SETUP_IDX_LAST  = 8'h27;
	localparam logic [7:0]  ROUTE_IDX       = 8'h40;
	localparam int          NUM_CHAN        = 16;
	localparam int          NUM_SETUP       = 8;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [15:0] SETUP_RESET     = 16'h1000;
	localparam logic [15:0] CHAN0_RESET     = 16'h8001;
	localparam logic [15:0] CHANX_RESET     = 16'h0001;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam logic [15:0] SETUP_WR_MASK   = 16'h1F30;
	localparam logic [15:0] CHAN_WR_MASK    = 16'hF3FF;
	localparam int          CODING_BIT      = 12;
	localparam int          REFP_BIT        = 11;
	localparam int          REFN_BIT        = 10;
	localparam int          INBUF_LSB       = 8;
	localparam int          REFSEL_LSB      = 4;
	localparam int          SETIDX_LSB      = 12;
	localparam int          PAIR_LSB        = 0;

	////////////////////////////////////////////////////////////////////////
	// Pin pair codes with a defined routing
	localparam logic [9:0]  PAIR_HV10_COM   = 10'h150;
	localparam logic [9:0]  PAIR_LL11_15    = 10'h16F;
	localparam logic [9:0]  PAIR_LL12_15    = 10'h18F;
	localparam logic [9:0]  PAIR_LL13_15    = 10'h1AF;
	localparam logic [9:0]  PAIR_LL14_15    = 10'h1CF;

	localparam logic [1:0]  INBUF_OFF       = 2'h0;
	localparam logic [1:0]  INBUF_ON        = 2'h3;

	typedef enum logic [1:0] {
		ACS_REF_EXT  = 2'h0,
		ACS_REF_RSVD = 2'h1,
		ACS_REF_INT  = 2'h2,
		ACS_REF_SUP  = 2'h3
	} acs_ref_t;

	typedef enum logic [2:0] {
		ACS_ROUTE_NONE,
		ACS_ROUTE_HV10_COM,
		ACS_ROUTE_LL11_15,
		ACS_ROUTE_LL12_15,
		ACS_ROUTE_LL13_15,
		ACS_ROUTE_LL14_15
	} acs_route_t;

	// Analog controls for the setup of the channel in use
	typedef struct packed {
		logic       bipolar;
		logic       ref_pos_buffer_en;
		logic       ref_neg_buffer_en;
		logic       analog_buffer_en;
		acs_ref_t   reference_source_select;
	} acs_setup_ctl_t;

	typedef struct packed {
		logic [31:0] paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} acs_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} acs_apb_rsp_t;

endpackage : acs_pkg

// ---- hdl/acs_setup_decode.sv ----
// Decoder from a setup register word to its analog controls.
// Assumes the word holds only writable fields; purely combinational.
`timescale 1ns/1ps
module acs_setup_decode (
	input  wire logic [15:0]            setup_word,
	output acs_pkg::acs_setup_ctl_t     ctl
);
	import acs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Field split; reserved input buffer codes read as off
	always_comb begin
		ctl.bipolar           = setup_word[CODING_BIT];
		ctl.ref_pos_buffer_en = setup_word[REFP_BIT];
		ctl.ref_neg_buffer_en = setup_word[REFN_BIT];
		ctl.analog_buffer_en  =
			(setup_word[INBUF_LSB +: 2] == INBUF_ON);
		ctl.reference_source_select =
			acs_ref_t'(setup_word[REFSEL_LSB +: 2]);
	end

endmodule : acs_setup_decode

// ---- hdl/acs_regs.sv ----
// Channel and setup configuration register bank behind an APB slave.
// Assumes one clock and a 32-bit APB master; zero wait states.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module acs_regs (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic [31:0]            paddr,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic [3:0]             active_channel,
	output acs_pkg::acs_setup_ctl_t     setup_ctl,
	output logic [9:0]                  pin_pair_select,
	output acs_pkg::acs_route_t         route_sel,
	output logic                        ref_internal_needed
);
	import acs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Storage
	logic [15:0]    setup_r [NUM_SETUP];
	logic [15:0]    chan_r  [NUM_CHAN];
	logic [31:0]    prdata_nxt;
	logic           hit_nxt;
	logic [15:0]    cur_chan;
	logic [15:0]    cur_setup;
	acs_setup_ctl_t ctl_nxt;
	acs_route_t     route_nxt;
	logic [7:0]     idx;
	logic           wr_en;
	logic           rd_en;

	// Byte address is four times the printed index
	assign idx   = paddr[9:2];
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;

	////////////////////////////////////////////////////////////////////////
	// Pin pair code to routing; unlisted codes leave nothing routed
	function automatic acs_route_t route_of(input logic [9:0] code);
		case (code)
			PAIR_HV10_COM: route_of = ACS_ROUTE_HV10_COM;
			PAIR_LL11_15:  route_of = ACS_ROUTE_LL11_15;
			PAIR_LL12_15:  route_of = ACS_ROUTE_LL12_15;
			PAIR_LL13_15:  route_of = ACS_ROUTE_LL13_15;
			PAIR_LL14_15:  route_of = ACS_ROUTE_LL14_15;
			default:       route_of = ACS_ROUTE_NONE;
		endcase
	endfunction : route_of

	function automatic logic in_setup(input logic [7:0] i);
		in_setup = (i >= SETUP_IDX_FIRST) && (i <= SETUP_IDX_LAST);
	endfunction : in_setup

	function automatic logic in_chan(input logic [7:0] i);
		in_chan = (i >= CHAN_IDX_FIRST) && (i < SETUP_IDX_FIRST);
	endfunction : in_chan

	////////////////////////////////////////////////////////////////////////
	// Setup registers; reserved bits never stored so they read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_SETUP; i++) begin
				setup_r[i] <= SETUP_RESET;
			end
		end else if (wr_en && in_setup(idx)) begin
			setup_r[idx[2:0]] <= pwdata[15:0] & SETUP_WR_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Channel registers; bits 11:10 are reserved and masked
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_r[0] <= CHAN0_RESET;
			for (int i = 1; i < NUM_CHAN; i++) begin
				chan_r[i] <= CHANX_RESET;
			end
		end else if (wr_en && in_chan(idx)) begin
			chan_r[idx[3:0]] <= pwdata[15:0] & CHAN_WR_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux, sampled in setup so data stands in the access phase
	always_comb begin
		prdata_nxt = 32'h0000_0000;
		hit_nxt    = 1'b1;
		if (in_setup(idx)) begin
			prdata_nxt[15:0] = setup_r[idx[2:0]];
		end else if (in_chan(idx)) begin
			prdata_nxt[15:0] = chan_r[idx[3:0]];
		end else if (idx == ROUTE_IDX) begin
			prdata_nxt[2:0] = route_sel;
		end else begin
			hit_nxt = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata <= prdata_nxt;
		end
	end

	// Ready only in the access phase, with no wait; error flags unmapped access in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !hit_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Controls for the channel being converted; registered outputs
	assign cur_chan  = chan_r[active_channel];
	assign cur_setup = setup_r[cur_chan[SETIDX_LSB +: 3]];
	assign route_nxt = route_of(cur_chan[PAIR_LSB +: 10]);

	acs_setup_decode u_dec (
		.setup_word (cur_setup),
		.ctl        (ctl_nxt)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			setup_ctl           <= '0;
			pin_pair_select     <= 10'h000;
			route_sel           <= ACS_ROUTE_NONE;
			ref_internal_needed <= 1'b0;
		end else begin
			setup_ctl       <= ctl_nxt;
			pin_pair_select <= cur_chan[PAIR_LSB +: 10];
			route_sel       <= route_nxt;
			// Host must also turn the reference on in mode register
			ref_internal_needed <=
				(ctl_nxt.reference_source_select == ACS_REF_INT);
		end
	end

endmodule : acs_regs

// ---- tb/acs_regs_properties.sv ----
// Timing and decode checks for the channel and setup register bank.
// Assumes it is bound to acs_regs and sees only that module's ports.
`timescale 1ns/1ps
module acs_regs_properties
	import acs_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [31:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input acs_setup_ctl_t   setup_ctl,
	input wire logic [9:0]  pin_pair_select,
	input acs_route_t       route_sel,
	input wire logic        ref_internal_needed
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Setup phase of an APB transfer
	sequence s_setup;
		psel && !penable;
	endsequence

	// Zero wait states: answer in the access cycle only
	a_ready_next: assert property (s_setup |=> pready && penable)
		else $error("no answer after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready held too long");
	// Unmapped reads must not leak stale data
	a_err_zero: assert property (pslverr && !pwrite |-> pready && !prdata)
		else $error("error read not zero");
	a_rsvd_zero: assert property (pready && !pwrite && paddr >= 32'h80 &&
		paddr <= 32'h9C |-> !(prdata & ~{16'h0, SETUP_WR_MASK}))
		else $error("reserved setup bits read set");
	// Route and pair are registered together, so they agree each cycle
	a_route_hv: assert property (pin_pair_select == 10'h150 |->
		route_sel == ACS_ROUTE_HV10_COM)
		else $error("high voltage route wrong");
	a_route_low11: assert property (pin_pair_select == 10'h16F |->
		route_sel == ACS_ROUTE_LL11_15)
		else $error("low level eleven route wrong");
	a_route_low14: assert property (pin_pair_select == 10'h1CF |->
		route_sel == ACS_ROUTE_LL14_15)
		else $error("low level fourteen route wrong");
	a_ref_internal: assert property (ref_internal_needed ==
		(setup_ctl.reference_source_select == ACS_REF_INT))
		else $error("internal reference flag wrong");
endmodule : acs_regs_properties

bind acs_regs acs_regs_properties chk_u (.pclk, .presetn, .paddr, .psel,
	.penable, .pwrite, .prdata, .pready, .pslverr, .setup_ctl,
	.pin_pair_select, .route_sel, .ref_internal_needed);

// ---- tb/acs_regs_bench.sv ----
// Self-checking bench for the channel and setup register bank.
// Assumes the checker file is compiled alongside; APB master is here.
`timescale 1ns/1ps
module acs_regs_bench;
	import acs_pkg::*;
	logic           pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [31:0]    paddr, pwdata, prdata, rd;
	logic           er, ref_internal_needed;
	logic [3:0]     active_channel;
	logic [9:0]     pin_pair_select;
	acs_setup_ctl_t setup_ctl;
	acs_route_t     route_sel;
	int             fails, total_checks;
	// Last code has no special route
	localparam logic [9:0] CODES [6] = '{10'h150, 10'h16F, 10'h18F,
		10'h1AF, 10'h1CF, 10'h16C};

	acs_regs dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .active_channel, .setup_ctl,
		.pin_pair_select, .route_sel, .ref_internal_needed);

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		if (fails == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h, want %h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; a bounded wait so a dead slave ends the run
	task automatic apb(input logic w, input logic [31:0] a, d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
			if (n > 16) begin
				fails++;
				end_of_test();
			end
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic logic [31:0] sa(input int i);
		return 32'h80 + 32'(4 * i);
	endfunction : sa

	function automatic logic [31:0] ca(input int i);
		return 32'h40 + 32'(4 * i);
	endfunction : ca

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, sa(i), 32'h0);
			check(rd, 32'h1000);
		end
		apb(1'b0, ca(1), 32'h0);
		check(rd[9:0], 32'h1);
		check(32'(setup_ctl), 32'h20);
	endtask : t_reset

	// Decoded controls lag the register write by one edge
	task automatic t_fields;
		apb(1'b1, sa(3), 32'hFFFF);
		apb(1'b0, sa(3), 32'h0);
		check(rd, 32'h1F30);
		apb(1'b1, ca(0), 32'h3001);
		repeat (2) @(posedge pclk);
		check(32'(setup_ctl), 32'h3F);
		apb(1'b1, sa(3), 32'h0820);
		repeat (2) @(posedge pclk);
		check(32'(setup_ctl), 32'h12);
		check(32'(ref_internal_needed), 32'h1);
		// Only the legal on code is written; 01 and 10 are host-forbidden
		apb(1'b1, sa(3), 32'h1300);
		repeat (2) @(posedge pclk);
		check(32'(setup_ctl), 32'h24);
	endtask : t_fields

	task automatic t_routes;
		active_channel <= 4'h2;
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, ca(2), 32'h1000 | 32'(CODES[i]));
			repeat (2) @(posedge pclk);
			check(32'(pin_pair_select), 32'(CODES[i]));
			check(32'(route_sel), (i < 5) ? 32'(i + 1) : 32'h0);
			apb(1'b0, 32'h100, 32'h0);
			check(rd, (i < 5) ? 32'(i + 1) : 32'h0);
		end
		check(32'(setup_ctl), 32'h20);
	endtask : t_routes

	task automatic t_unmapped;
		apb(1'b1, 32'hA0, 32'h0);
		apb(1'b0, 32'hA0, 32'h0);
		check(32'(er), 32'h1);
		check(rd, 32'h0);
		apb(1'b0, sa(7), 32'h0);
		check(rd, 32'h1000);
	endtask : t_unmapped

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		active_channel = 4'h0;
		fails = 0;
		total_checks = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_fields();
		t_routes();
		t_unmapped();
		end_of_test();
	end
endmodule : acs_regs_bench
